// ==== rtl/xbi_ext_bus.sv ====
// external parallel bus interface: core request port to program, data, i/o
// and global spaces over a shared 16-bit address and data bus
// assumes the core holds a request stable until req_ready_o is high,
// and that the pad ring resolves each output and its active-low enable
//
// Operation
// - all external words travel on a 16-bit data bus, bit 15 MSB
// - data bus floats unless write data driven, and during reset
// - float input low floats data, address and every control output
// - a 16-bit address bus, bit 15 MSB, selects external locations
// - program select stays high, low only for off-chip program access
// - data select stays high, low only for off-chip data and global accesses
// - i/o select stays high, low only during external i/o access
// - ready sampled each cycle once the software waits run out; low means wait one cycle, sample again
// - direction line high by default, low only during external write
// - read strobe asserted on every external read of any space
// - mode register bit 15 turns read strobe pin into inverted direction
// - software wait states 0 to 7, plus hardware waits via ready
// - four spaces: program, data, i/o of 64K, global of 32K
// - write enable low on every external write while data driven
// - bus-cycle strobe stays high, low only during an external cycle
// - bus request asserted for every global data-space access
`timescale 1ns/1ns
`include "xbi_cfg.svh"

module xbi_ext_bus
  import xbi_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_i,
  input wire xbi_space_t req_space_i,
  input wire logic req_write_i,
  input wire logic [`XBI_ADDR_W-1:0] req_addr_i,
  input wire logic [`XBI_DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic ack_o,
  output logic [`XBI_DATA_W-1:0] rdata_o,
  input wire logic [`XBI_WS_W-1:0] wait_count_i,
  input wire logic [`XBI_MODE_W-1:0] processor_mode_status_reg_i,
  input wire logic float_n_i,
  input wire logic ready_i,
  input wire logic [`XBI_DATA_W-1:0] ext_data_bus_i,
  output logic [`XBI_DATA_W-1:0] ext_data_bus_o,
  output logic ext_data_oe_n_o,
  output logic [`XBI_ADDR_W-1:0] ext_addr_bus_o,
  output logic ctrl_oe_n_o,
  output logic program_space_sel_n_o,
  output logic data_space_sel_n_o,
  output logic io_space_sel_n_o,
  output logic bus_cycle_strobe_n_o,
  output logic global_access_request_n_o,
  output logic rw_o,
  output logic read_strobe_n_o,
  output logic write_enable_n_o
);

  xbi_state_t state;
  xbi_state_t next_state;
  logic ws_done;
  logic start;
  logic read_pin_function_sel;

  // pin registers: address, data and strobe pins come straight from flip-flops; the read pin mux and output enables do not
  logic [`XBI_ADDR_W-1:0] addr;
  logic [`XBI_ADDR_W-1:0] next_addr;
  logic [`XBI_DATA_W-1:0] wdata;
  logic [`XBI_DATA_W-1:0] next_wdata;
  logic [`XBI_DATA_W-1:0] rdata;
  logic [`XBI_DATA_W-1:0] next_rdata;
  logic prog_n;
  logic next_prog_n;
  logic data_n;
  logic next_data_n;
  logic io_n;
  logic next_io_n;
  logic strobe_n;
  logic next_strobe_n;
  logic greq_n;
  logic next_greq_n;
  logic rw;
  logic next_rw;
  logic rd_n;
  logic next_rd_n;
  logic we_n;
  logic next_we_n;
  logic hold_write;
  logic next_hold_write;
  logic hold_global;
  logic next_hold_global;

  assign start = req_i && (state == XBI_ST_IDLE);
  assign read_pin_function_sel = processor_mode_status_reg_i[`XBI_RPF_BIT];

  xbi_wait_gen u_wait (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(start),
    .count_i(wait_count_i),
    .done_o(ws_done)
  );

  // sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      XBI_ST_IDLE: begin
        if (req_i) begin
          next_state = XBI_ST_ACCESS;
        end
      end
      XBI_ST_ACCESS: begin
        // ready is looked at only after the programmed waits run out
        if (ws_done && ready_i) begin
          next_state = XBI_ST_FINISH;
        end
      end
      XBI_ST_FINISH: begin
        next_state = XBI_ST_IDLE;
      end
      default: begin
        next_state = XBI_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= XBI_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // pin values follow next_state so pins and state change on the same edge
  always_comb begin
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_hold_write = hold_write;
    next_hold_global = hold_global;
    next_prog_n = `XBI_PIN_HI;
    next_data_n = `XBI_PIN_HI;
    next_io_n = `XBI_PIN_HI;
    next_strobe_n = `XBI_PIN_HI;
    next_greq_n = `XBI_PIN_HI;
    next_rw = `XBI_PIN_HI;
    next_rd_n = `XBI_PIN_HI;
    next_we_n = `XBI_PIN_HI;
    if (start) begin
      next_wdata = req_wdata_i;
      next_hold_write = req_write_i;
      next_hold_global = (req_space_i == XBI_SP_GLOBAL);
      next_addr = req_addr_i;
      // global space is 32K words, mapped onto the upper half of the bus
      if (req_space_i == XBI_SP_GLOBAL) begin
        next_addr = {`XBI_GLOBAL_TOP, req_addr_i[`XBI_GLOBAL_W-1:0]};
      end
      next_prog_n = !(req_space_i == XBI_SP_PROG);
      next_data_n = !(req_space_i == XBI_SP_DATA || req_space_i == XBI_SP_GLOBAL);
      next_io_n = !(req_space_i == XBI_SP_IO);
    end
    if (next_state == XBI_ST_ACCESS) begin
      if (!start) begin
        next_prog_n = prog_n;
        next_data_n = data_n;
        next_io_n = io_n;
      end
      next_strobe_n = `XBI_PIN_LO;
      next_greq_n = !next_hold_global;
      next_rw = !next_hold_write;
      next_rd_n = next_hold_write;
      next_we_n = !next_hold_write;
    end
    if (state == XBI_ST_ACCESS && next_state == XBI_ST_FINISH && !hold_write) begin
      next_rdata = ext_data_bus_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      addr <= `XBI_ADDR_IDLE;
      wdata <= `XBI_DATA_IDLE;
      rdata <= `XBI_DATA_IDLE;
      hold_write <= `XBI_PIN_LO;
      hold_global <= `XBI_PIN_LO;
      prog_n <= `XBI_PIN_HI;
      data_n <= `XBI_PIN_HI;
      io_n <= `XBI_PIN_HI;
      strobe_n <= `XBI_PIN_HI;
      greq_n <= `XBI_PIN_HI;
      rw <= `XBI_PIN_HI;
      rd_n <= `XBI_PIN_HI;
      we_n <= `XBI_PIN_HI;
    end else begin
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      hold_write <= next_hold_write;
      hold_global <= next_hold_global;
      prog_n <= next_prog_n;
      data_n <= next_data_n;
      io_n <= next_io_n;
      strobe_n <= next_strobe_n;
      greq_n <= next_greq_n;
      rw <= next_rw;
      rd_n <= next_rd_n;
      we_n <= next_we_n;
    end
  end

  assign req_ready_o = (state == XBI_ST_IDLE);
  assign ack_o = (state == XBI_ST_FINISH);
  assign rdata_o = rdata;
  assign ext_addr_bus_o = addr;
  assign ext_data_bus_o = wdata;
  assign program_space_sel_n_o = prog_n;
  assign data_space_sel_n_o = data_n;
  assign io_space_sel_n_o = io_n;
  assign bus_cycle_strobe_n_o = strobe_n;
  assign global_access_request_n_o = greq_n;
  assign rw_o = rw;
  assign write_enable_n_o = we_n;
  // the pin can carry the inverted direction line for glue-free memories
  assign read_strobe_n_o = read_pin_function_sel ? !rw : rd_n;

  // float acts on both enables and reset on the data enable directly, with no clock delay
  assign ctrl_oe_n_o = !float_n_i;
  assign ext_data_oe_n_o = !float_n_i || reset_i || rw;

  // ---- checks ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  logic in_access;
  assign in_access = (state == XBI_ST_ACCESS);

  sequence s_accept_max_waits;
    start && wait_count_i == `XBI_WS_MAX;
  endsequence

  sequence s_held_access8;
    in_access [*8];
  endsequence

  sequence s_access_stalled;
    in_access && ws_done && !ready_i;
  endsequence

  a_data_hiz_read:
    assert property (rw_o |-> ext_data_oe_n_o)
    else $error("data bus driven while direction line high");

  a_data_hiz_reset:
    assert property (@(posedge clk_i) disable iff (1'h0) reset_i |-> ext_data_oe_n_o)
    else $error("data bus driven during reset");

  a_float_all_hiz:
    assert property (!float_n_i |-> ctrl_oe_n_o && ext_data_oe_n_o)
    else $error("outputs enabled while float input low");

  a_prog_sel_only:
    assert property (!program_space_sel_n_o |-> in_access && data_space_sel_n_o && io_space_sel_n_o)
    else $error("program select low outside a program access");

  a_data_sel_only:
    assert property (start && req_space_i == XBI_SP_DATA |=> !data_space_sel_n_o && program_space_sel_n_o)
    else $error("data select wrong for data access");

  a_io_sel_only:
    assert property (start && req_space_i == XBI_SP_IO |=> !io_space_sel_n_o && data_space_sel_n_o)
    else $error("i/o select wrong for i/o access");

  a_ready_stall:
    assert property (s_access_stalled |=> in_access && !bus_cycle_strobe_n_o)
    else $error("access ended while ready low");

  a_wait_states_max:
    assert property (s_accept_max_waits |=> s_held_access8)
    else $error("seven wait states not honoured");

  a_waits_before_ready:
    assert property (start && wait_count_i == `XBI_WS_TWO |=> in_access [*3])
    else $error("access ended before software waits ran out");

  a_read_data_taken:
    assert property (in_access && ws_done && ready_i && rw_o |=> ack_o && rdata_o == $past(ext_data_bus_i))
    else $error("read data not captured at completion");

  a_write_enable:
    assert property (!write_enable_n_o |-> !rw_o && in_access && !(ext_data_oe_n_o && float_n_i))
    else $error("write enable without a driven write");

  a_read_strobe:
    assert property (in_access && rw_o && !read_pin_function_sel |-> !read_strobe_n_o)
    else $error("read strobe missing on external read");

  a_read_pin_alt:
    assert property (read_pin_function_sel |-> read_strobe_n_o == !rw_o)
    else $error("read pin not inverted direction line");

  a_strobe_cycle:
    assert property (bus_cycle_strobe_n_o != in_access)
    else $error("bus-cycle strobe out of step with access");

  a_global_request:
    assert property (start && req_space_i == XBI_SP_GLOBAL |=> !global_access_request_n_o && ext_addr_bus_o[`XBI_ADDR_W-1])
    else $error("global access without bus request");

  a_direction_idle:
    assert property (!in_access |-> rw_o)
    else $error("direction line low outside a write");

  a_addr_stable:
    assert property (in_access && $past(in_access) |-> $stable(ext_addr_bus_o))
    else $error("address changed during access");

endmodule

// ==== rtl/xbi_cfg.svh ====
// constants of the external bus interface: widths, field positions, idle levels
// assumes inclusion by the package and the design modules of this block
`ifndef XBI_CFG_SVH
`define XBI_CFG_SVH

`define XBI_DATA_W 16
`define XBI_ADDR_W 16
`define XBI_WS_W 3
`define XBI_MODE_W 16
`define XBI_RPF_BIT 15
`define XBI_GLOBAL_W 15
`define XBI_GLOBAL_TOP 1'h1
`define XBI_ADDR_IDLE 16'h0000
`define XBI_DATA_IDLE 16'h0000
`define XBI_WS_ZERO 3'h0
`define XBI_WS_ONE 3'h1
`define XBI_WS_TWO 3'h2
`define XBI_WS_MAX 3'h7
`define XBI_PIN_HI 1'h1
`define XBI_PIN_LO 1'h0

`endif

// ==== rtl/xbi_pkg.sv ====
// types shared by the external bus interface modules
// assumes the constants header is on the include path
`include "xbi_cfg.svh"

package xbi_pkg;

  typedef enum logic [1:0] {
    XBI_SP_PROG = 2'h0,
    XBI_SP_DATA = 2'h1,
    XBI_SP_IO = 2'h2,
    XBI_SP_GLOBAL = 2'h3
  } xbi_space_t;

  typedef enum logic [2:0] {
    XBI_ST_IDLE = 3'h1,
    XBI_ST_ACCESS = 3'h2,
    XBI_ST_FINISH = 3'h4
  } xbi_state_t;

endpackage

// ==== rtl/xbi_wait_gen.sv ====
// software wait-state counter for one external access
// assumes load_i pulses in the cycle the access is accepted
`timescale 1ns/1ns
`include "xbi_cfg.svh"

module xbi_wait_gen
  import xbi_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [`XBI_WS_W-1:0] count_i,
  output logic done_o
);

  logic [`XBI_WS_W-1:0] remain;
  logic [`XBI_WS_W-1:0] next_remain;

  always_comb begin
    next_remain = remain;
    if (load_i) begin
      next_remain = count_i;
    end else if (remain != `XBI_WS_ZERO) begin
      next_remain = remain - `XBI_WS_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      remain <= `XBI_WS_ZERO;
    end else begin
      remain <= next_remain;
    end
  end

  assign done_o = (remain == `XBI_WS_ZERO);

endmodule

// ==== testbench/xbi_mem_model.sv ====
// external memory and i/o model behind the bus pins: one small store per space
// assumes the bench resolves the data pins and sets how long ready stays low
`timescale 1ns/1ns

module xbi_mem_model (
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic prog_n_i,
  input wire logic io_n_i,
  input wire logic glob_n_i,
  input wire logic strobe_n_i,
  input wire logic rw_i,
  input wire logic we_n_i,
  input wire logic [3:0] hold_i,
  output logic ready_o,
  output logic [15:0] data_o
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h5A5A;
  logic [3:0] cnt = 4'h0;
  logic [7:0] key;
  logic drive;
  assign key = {(!prog_n_i ? 2'h0 : !io_n_i ? 2'h2 : !glob_n_i ? 2'h3 : 2'h1), addr_i[5:0]};
  assign drive = !strobe_n_i && rw_i;
  // ready low for the first hold_i cycles of each strobe, then high
  assign ready_o = (cnt >= hold_i);
  // released bus shows the inverse of the last word, so a stale value never passes
  assign data_o = drive ? mem[key] : ~last;
  always @(posedge clk_i) begin
    cnt <= strobe_n_i ? 4'h0 : cnt + 4'h1;
    if (!we_n_i) mem[key] <= data_i;
    if (drive) last <= mem[key];
  end
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench of the external bus interface with a memory model
// assumes the design files and the constants header are compiled first
`timescale 1ns/1ns

module tb_top;
  import xbi_pkg::*;
  logic clk_i, reset_i, req_i, req_write_i, float_n_i, ready_i, req_ready_o, ack_o;
  xbi_space_t req_space_i;
  logic [15:0] req_addr_i, req_wdata_i, rdata_o, mode, bus, dut_d, mem_d, ext_addr_bus_o;
  logic [2:0] wait_count_i;
  logic [3:0] hold;
  logic prog_sel_n, data_sel_n, io_sel_n, stb, greq, rw, rd, we, doe, coe;
  logic [8:0] pins;
  int n_errors = 0;
  int tests_run = 0;

  assign pins = {prog_sel_n, data_sel_n, io_sel_n, stb, greq, rw, rd, we, doe};
  assign bus = doe ? mem_d : dut_d;

  xbi_ext_bus i_dut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .req_space_i(req_space_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .ack_o(ack_o), .rdata_o(rdata_o), .wait_count_i(wait_count_i),
    .processor_mode_status_reg_i(mode), .float_n_i(float_n_i), .ready_i(ready_i),
    .ext_data_bus_i(bus), .ext_data_bus_o(dut_d), .ext_data_oe_n_o(doe),
    .ext_addr_bus_o(ext_addr_bus_o), .ctrl_oe_n_o(coe), .program_space_sel_n_o(prog_sel_n),
    .data_space_sel_n_o(data_sel_n), .io_space_sel_n_o(io_sel_n), .bus_cycle_strobe_n_o(stb),
    .global_access_request_n_o(greq), .rw_o(rw), .read_strobe_n_o(rd), .write_enable_n_o(we));

  xbi_mem_model i_mem (.clk_i(clk_i), .addr_i(ext_addr_bus_o), .data_i(bus), .prog_n_i(prog_sel_n),
    .io_n_i(io_sel_n), .glob_n_i(greq), .strobe_n_i(stb), .rw_i(rw), .we_n_i(we), .hold_i(hold),
    .ready_o(ready_i), .data_o(mem_d));

  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // idle pins: every strobe high, read pin low only when it carries the inverted direction line
  function automatic logic [15:0] idle_pins();
    return {7'h0, 6'h3F, !mode[15], 2'h3};
  endfunction

  // one access; entered 1 ns after an edge with the design idle
  task automatic acc(input logic [1:0] sp, input logic wr, input logic [15:0] a, d,
                     input logic [2:0] w, input logic [3:0] n, output logic [15:0] q);
    logic [15:0] k;
    logic [15:0] e;
    hold = n;
    req_space_i = xbi_space_t'(sp);
    req_write_i = wr;
    req_addr_i = a;
    req_wdata_i = d;
    wait_count_i = w;
    req_i = 1'h1;
    @(posedge clk_i);
    #1;
    req_i = 1'h0;
    e = {7'h0, sp != 2'h0, !(sp == 2'h1 || sp == 2'h3), sp != 2'h2, 1'h0, sp != 2'h3, !wr, wr, !wr, !wr};
    chk("pins", e, {7'h0, pins});
    chk("busy handshake", 16'h0000, {14'h0, req_ready_o, ack_o});
    chk("addr", sp == 2'h3 ? {1'h1, a[14:0]} : a, ext_addr_bus_o);
    if (wr) chk("wdata", d, dut_d);
    k = 16'h0;
    while (ack_o !== 1'h1 && k < 16'h28) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk("latency", 16'h1 + 16'(w) + (n > 4'(w) ? 16'(n) - 16'(w) : 16'h0), k);
    chk("finish pins", idle_pins(), {7'h0, pins});
    q = rdata_o;
    @(posedge clk_i);
    #1;
    // ack is a single-cycle pulse and the port is free again right after it
    chk("idle handshake", 16'h0002, {14'h0, req_ready_o, ack_o});
  endtask

  task automatic t_spaces();
    logic [15:0] q;
    for (int s = 0; s < 4; s++) acc(2'(s), 1'h1, 16'h0010 + 16'(s), 16'hC3A0 + 16'(s), 3'h0, 4'h0, q);
    for (int s = 0; s < 4; s++) begin
      acc(2'(s), 1'h0, 16'h0010 + 16'(s), 16'h0000, 3'h0, 4'h0, q);
      chk("rdata", 16'hC3A0 + 16'(s), q);
    end
    $display("spaces done");
  endtask

  task automatic t_waits();
    logic [15:0] q;
    logic [2:0] ws [4] = '{3'h7, 3'h1, 3'h0, 3'h3};
    logic [3:0] hs [4] = '{4'h0, 4'h3, 4'h2, 4'h3};
    for (int i = 0; i < 4; i++) begin
      acc(2'h2, 1'h0, 16'h0012, 16'h0000, ws[i], hs[i], q);
      chk("wait rdata", 16'hC3A2, q);
    end
    $display("waits done");
  endtask

  task automatic t_mode();
    logic [15:0] q;
    mode = 16'h8000;
    #1;
    chk("mode idle", idle_pins(), {7'h0, pins});
    @(posedge clk_i);
    #1;
    acc(2'h1, 1'h1, 16'h0020, 16'h1E5F, 3'h2, 4'h0, q);
    acc(2'h1, 1'h0, 16'h0020, 16'h0000, 3'h0, 4'h1, q);
    chk("mode rdata", 16'h1E5F, q);
    mode = 16'h0000;
    $display("mode done");
  endtask

  task automatic t_float();
    float_n_i = 1'h0;
    #1;
    chk("float", 16'h0003, {14'h0, coe, doe});
    @(posedge clk_i);
    #1;
    float_n_i = 1'h1;
    #1;
    chk("unfloat", 16'h0003, {14'h0, coe, doe} ^ 16'h0002);
    $display("float done");
  endtask

  initial begin
    #(40 * 3000);
    n_errors++;
    report_and_stop();
  end

  initial begin
    reset_i = 1'h1;
    req_i = 1'h0;
    req_space_i = XBI_SP_PROG;
    req_write_i = 1'h0;
    req_addr_i = 16'h0000;
    req_wdata_i = 16'h0000;
    wait_count_i = 3'h0;
    mode = 16'h0000;
    float_n_i = 1'h1;
    hold = 4'h0;
    #5;
    chk("reset data oe", 16'h0001, {15'h0, doe});
    repeat (2) @(posedge clk_i);
    #1;
    reset_i = 1'h0;
    chk("reset pins", idle_pins(), {7'h0, pins});
    $display("reset done");
    t_spaces();
    t_waits();
    t_mode();
    t_float();
    report_and_stop();
  end
endmodule
